// ### ascr_host_model.sv
module ascr_host_model (
  input  wire logic            clock,
  output logic                 reg_wr_en,
  output logic                 reg_rd_en,
  output ascr_pkg::ascr_addr_t reg_addr,
  output ascr_pkg::ascr_byte_t reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 9'h000;
    reg_wr_data = 8'h00;
  end
  // one strobe cycle per request; gap 0 keeps strobes up for back-to-back traffic,
  // idle lines show inverted leftovers so a stale value never looks current
  task automatic xfer(input logic w, input ascr_pkg::ascr_addr_t a,
                      input ascr_pkg::ascr_byte_t d, input int gap);
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge clock);
    if (gap > 0)
    begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
      repeat (gap) @(negedge clock);
    end
  endtask : xfer
  // the limit is only put in use by a separate commit write
  task automatic commit(input int gap);
    xfer(1'b1, 9'h0FF, 8'h01, gap);
  endtask : commit
endmodule : ascr_host_model

// ### ascr_local_bank.sv
`include "ascr_map.svh"

// per-channel local state: one two-bit entry per channel, written only where selected
module ascr_local_bank #(
  parameter int NUM_DATA = 8,
  parameter int NUM_CLK  = 2
) (
  input  wire logic                              clock,
  input  wire logic                              nrst,
  input  wire logic                              wr_en,
  input  wire logic [NUM_DATA+NUM_CLK-1:0]       sel,
  input  wire ascr_pkg::ascr_local_t             wr_data,
  output logic      [2*(NUM_DATA+NUM_CLK)-1:0]   state_ff
);
  localparam int NUM = NUM_DATA + NUM_CLK;

  logic [2*NUM-1:0] nxt_state;

  // clock channels only take the power-down bit, output reset stays zero there
  always_comb
  begin
    nxt_state = state_ff;
    for (int i = 0; i < NUM; i++)
    begin
      if (wr_en && sel[i])
      begin
        nxt_state[2*i+`ASCR_PWR_DOWN_BIT] = wr_data[`ASCR_PWR_DOWN_BIT];
        if (i < NUM_DATA)
        begin
          nxt_state[2*i+`ASCR_OUT_RESET_BIT] = wr_data[`ASCR_OUT_RESET_BIT];
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end
endmodule : ascr_local_bank

// ### ascr_map.svh
`ifndef ASCR_MAP_SVH
`define ASCR_MAP_SVH

// register offsets
`define ASCR_CHAN_SEL_LOW_ADDR     9'h004
`define ASCR_CHAN_SEL_HIGH_ADDR    9'h005
`define ASCR_TEST_ONE_LOW_ADDR     9'h019
`define ASCR_TEST_ONE_HIGH_ADDR    9'h01A
`define ASCR_TEST_TWO_LOW_ADDR     9'h01B
`define ASCR_TEST_TWO_HIGH_ADDR    9'h01C
`define ASCR_STREAM_CTRL_ADDR      9'h021
`define ASCR_CHAN_PWR_RST_ADDR     9'h022
`define ASCR_COMMIT_ADDR           9'h0FF
`define ASCR_RATE_LIMIT_ADDR       9'h100
`define ASCR_IO_CTRL_TWO_ADDR      9'h101
`define ASCR_IO_CTRL_THREE_ADDR    9'h102
`define ASCR_SYNC_CTRL_ADDR        9'h109

// writable bit masks; open bits are zero here
`define ASCR_CHAN_SEL_LOW_MASK     8'h0F
`define ASCR_CHAN_SEL_HIGH_MASK    8'h3F
`define ASCR_STREAM_CTRL_MASK      8'hFB
`define ASCR_CHAN_PWR_RST_MASK     8'h03
`define ASCR_RATE_LIMIT_MASK       8'h77
`define ASCR_IO_CTRL_TWO_MASK      8'h01
`define ASCR_IO_CTRL_THREE_MASK    8'h08
`define ASCR_SYNC_CTRL_MASK        8'h03

// reset values
`define ASCR_CHAN_SEL_LOW_RST      8'h0F
`define ASCR_CHAN_SEL_HIGH_RST     8'h3F
`define ASCR_STREAM_CTRL_RST       8'h41
`define ASCR_ZERO_RST              8'h00

// field positions
`define ASCR_COMMIT_BIT            0
`define ASCR_STREAM_LSB_FIRST_BIT  7
`define ASCR_STREAM_PLL_LOW_BIT    3
`define ASCR_LIMIT_ENABLE_BIT      6
`define ASCR_SDIO_PD_OFF_BIT       0
`define ASCR_CM_GEN_PD_BIT         3
`define ASCR_SYNC_ENABLE_BIT       0
`define ASCR_SYNC_NEXT_BIT         1
`define ASCR_PWR_DOWN_BIT          0
`define ASCR_OUT_RESET_BIT         1

`endif

// ### ascr_pkg.sv
package ascr_pkg;
  typedef logic [8:0] ascr_addr_t;
  typedef logic [7:0] ascr_byte_t;
  typedef logic [1:0] ascr_local_t;
endpackage : ascr_pkg

// ### ascr_regs.sv
// Function
// - global registers apply to all channels; local ones only to selected channels
// - bits 3:0 of both select registers pick the data channels for local writes
// - high select also picks clock channels, which take only power-down
// - all registers but the rate limit take effect on the write itself
// - writing one to commit bit 0 copies the rate limit into use
// - stream control: lsb-first, lane mode, pll low rate, bit count; reset 0x41
// - rate limit drives capability and resolution limits, never the sample rate
// - io control two bit 0 turns off the data pin pull-down
// - io control three bit 3 powers down the common-mode generator
`include "ascr_map.svh"

module ascr_regs (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  input  wire ascr_pkg::ascr_addr_t reg_addr,
  input  wire ascr_pkg::ascr_byte_t reg_wr_data,
  output ascr_pkg::ascr_byte_t      reg_rd_data,
  output logic                      reg_rd_valid,
  output logic [15:0]               test_word_one,
  output logic [15:0]               test_word_two,
  output logic                      out_lsb_first,
  output logic [2:0]                out_lane_mode,
  output logic                      pll_low_encode_rate,
  output logic [1:0]                out_bit_count,
  output logic [7:0]                chan_power_down,
  output logic [7:0]                chan_output_reset,
  output logic [1:0]                clk_chan_power_down,
  output logic                      limit_enable,
  output logic [1:0]                limit_resolution,
  output logic [2:0]                limit_rate,
  output logic                      sdio_pulldown_off,
  output logic                      common_mode_voltage_generator_pd,
  output logic                      sync_enable,
  output logic                      sync_next_only
);
  localparam int NUM_DATA = 8;
  localparam int NUM_CLK  = 2;
  localparam int NUM      = NUM_DATA + NUM_CLK;

  // open bits are dropped at the write so they can never read back as one
  function automatic ascr_pkg::ascr_byte_t masked(input ascr_pkg::ascr_byte_t d,
                                                  input ascr_pkg::ascr_byte_t m);
    masked = d & m;
  endfunction : masked

  function automatic logic hit(input ascr_pkg::ascr_addr_t a, input ascr_pkg::ascr_addr_t b);
    hit = (a == b);
  endfunction : hit

  ascr_pkg::ascr_byte_t sel_low_ff, sel_high_ff, t1l_ff, t1h_ff, t2l_ff, t2h_ff;
  ascr_pkg::ascr_byte_t stream_ff, limit_shadow_ff, limit_live_ff, io2_ff, io3_ff, sync_ff;
  ascr_pkg::ascr_byte_t nxt_sel_low, nxt_sel_high, nxt_t1l, nxt_t1h, nxt_t2l, nxt_t2h;
  ascr_pkg::ascr_byte_t nxt_stream, nxt_limit_shadow, nxt_limit_live, nxt_io2, nxt_io3;
  ascr_pkg::ascr_byte_t nxt_sync;
  ascr_pkg::ascr_byte_t rd_data_ff, nxt_rd_data;
  logic                 rd_valid_ff, nxt_rd_valid;
  logic [NUM-1:0]       local_sel;
  logic [2*NUM-1:0]     local_state;
  logic                 local_wr;

  // global registers: written whatever the channel selection says
  always_comb
  begin
    nxt_sel_low      = sel_low_ff;
    nxt_sel_high     = sel_high_ff;
    nxt_t1l          = t1l_ff;
    nxt_t1h          = t1h_ff;
    nxt_t2l          = t2l_ff;
    nxt_t2h          = t2h_ff;
    nxt_stream       = stream_ff;
    nxt_limit_shadow = limit_shadow_ff;
    nxt_limit_live   = limit_live_ff;
    nxt_io2          = io2_ff;
    nxt_io3          = io3_ff;
    nxt_sync         = sync_ff;
    if (reg_wr_en)
    begin
      case (reg_addr)
        `ASCR_CHAN_SEL_LOW_ADDR:  nxt_sel_low  = masked(reg_wr_data, `ASCR_CHAN_SEL_LOW_MASK);
        `ASCR_CHAN_SEL_HIGH_ADDR: nxt_sel_high = masked(reg_wr_data, `ASCR_CHAN_SEL_HIGH_MASK);
        `ASCR_TEST_ONE_LOW_ADDR:  nxt_t1l      = reg_wr_data;
        `ASCR_TEST_ONE_HIGH_ADDR: nxt_t1h      = reg_wr_data;
        `ASCR_TEST_TWO_LOW_ADDR:  nxt_t2l      = reg_wr_data;
        `ASCR_TEST_TWO_HIGH_ADDR: nxt_t2h      = reg_wr_data;
        `ASCR_STREAM_CTRL_ADDR:
          nxt_stream = masked(reg_wr_data, `ASCR_STREAM_CTRL_MASK);
        `ASCR_RATE_LIMIT_ADDR:    nxt_limit_shadow = masked(reg_wr_data, `ASCR_RATE_LIMIT_MASK);
        `ASCR_IO_CTRL_TWO_ADDR:   nxt_io2      = masked(reg_wr_data, `ASCR_IO_CTRL_TWO_MASK);
        `ASCR_IO_CTRL_THREE_ADDR: nxt_io3      = masked(reg_wr_data, `ASCR_IO_CTRL_THREE_MASK);
        `ASCR_SYNC_CTRL_ADDR:     nxt_sync     = masked(reg_wr_data, `ASCR_SYNC_CTRL_MASK);
        `ASCR_COMMIT_ADDR:
        begin
          // the rate limit is only handed over here, held until then in the shadow
          if (reg_wr_data[`ASCR_COMMIT_BIT])
            nxt_limit_live = limit_shadow_ff;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sel_low_ff      <= `ASCR_CHAN_SEL_LOW_RST;
      sel_high_ff     <= `ASCR_CHAN_SEL_HIGH_RST;
      t1l_ff          <= `ASCR_ZERO_RST;
      t1h_ff          <= `ASCR_ZERO_RST;
      t2l_ff          <= `ASCR_ZERO_RST;
      t2h_ff          <= `ASCR_ZERO_RST;
      stream_ff       <= `ASCR_STREAM_CTRL_RST;
      limit_shadow_ff <= `ASCR_ZERO_RST;
      limit_live_ff   <= `ASCR_ZERO_RST;
      io2_ff          <= `ASCR_ZERO_RST;
      io3_ff          <= `ASCR_ZERO_RST;
      sync_ff         <= `ASCR_ZERO_RST;
    end
    else
    begin
      sel_low_ff      <= nxt_sel_low;
      sel_high_ff     <= nxt_sel_high;
      t1l_ff          <= nxt_t1l;
      t1h_ff          <= nxt_t1h;
      t2l_ff          <= nxt_t2l;
      t2h_ff          <= nxt_t2h;
      stream_ff       <= nxt_stream;
      limit_shadow_ff <= nxt_limit_shadow;
      limit_live_ff   <= nxt_limit_live;
      io2_ff          <= nxt_io2;
      io3_ff          <= nxt_io3;
      sync_ff         <= nxt_sync;
    end
  end

  // local channel state: low select covers data 0-3, high covers data 4-7 and clocks
  assign local_sel = {sel_high_ff[5:4], sel_high_ff[3:0], sel_low_ff[3:0]};
  assign local_wr  = reg_wr_en && hit(reg_addr, `ASCR_CHAN_PWR_RST_ADDR);

  ascr_local_bank #(
    .NUM_DATA (NUM_DATA),
    .NUM_CLK  (NUM_CLK)
  ) u_local (
    .clock    (clock),
    .nrst     (nrst),
    .wr_en    (local_wr),
    .sel      (local_sel),
    .wr_data  (reg_wr_data[1:0]),
    .state_ff (local_state)
  );

  // read path; the local register shows the lowest selected channel, commit reads zero
  always_comb
  begin
    nxt_rd_valid = reg_rd_en;
    nxt_rd_data  = rd_data_ff;
    if (reg_rd_en)
    begin
      nxt_rd_data = 8'h00;
      case (reg_addr)
        `ASCR_CHAN_SEL_LOW_ADDR:  nxt_rd_data = sel_low_ff;
        `ASCR_CHAN_SEL_HIGH_ADDR: nxt_rd_data = sel_high_ff;
        `ASCR_TEST_ONE_LOW_ADDR:  nxt_rd_data = t1l_ff;
        `ASCR_TEST_ONE_HIGH_ADDR: nxt_rd_data = t1h_ff;
        `ASCR_TEST_TWO_LOW_ADDR:  nxt_rd_data = t2l_ff;
        `ASCR_TEST_TWO_HIGH_ADDR: nxt_rd_data = t2h_ff;
        `ASCR_STREAM_CTRL_ADDR:   nxt_rd_data = stream_ff;
        `ASCR_RATE_LIMIT_ADDR:    nxt_rd_data = limit_shadow_ff;
        `ASCR_IO_CTRL_TWO_ADDR:   nxt_rd_data = io2_ff;
        `ASCR_IO_CTRL_THREE_ADDR: nxt_rd_data = io3_ff;
        `ASCR_SYNC_CTRL_ADDR:     nxt_rd_data = sync_ff;
        `ASCR_CHAN_PWR_RST_ADDR:
        begin
          for (int i = NUM - 1; i >= 0; i--)
          begin
            if (local_sel[i])
              nxt_rd_data = {6'h00, local_state[2*i +: 2]};
          end
        end
        default: nxt_rd_data = 8'h00;                                  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // outputs are the register flops themselves
  assign reg_rd_data   = rd_data_ff;
  assign reg_rd_valid  = rd_valid_ff;
  assign test_word_one = {t1h_ff, t1l_ff};
  assign test_word_two = {t2h_ff, t2l_ff};
  assign out_lsb_first       = stream_ff[`ASCR_STREAM_LSB_FIRST_BIT];
  assign out_lane_mode       = stream_ff[6:4];
  assign pll_low_encode_rate = stream_ff[`ASCR_STREAM_PLL_LOW_BIT];
  assign out_bit_count       = stream_ff[1:0];

  for (genvar g = 0; g < NUM_DATA; g++)
  begin : g_data
    assign chan_power_down[g]   = local_state[2*g+`ASCR_PWR_DOWN_BIT];
    assign chan_output_reset[g] = local_state[2*g+`ASCR_OUT_RESET_BIT];
  end
  for (genvar g = 0; g < NUM_CLK; g++)
  begin : g_clk
    assign clk_chan_power_down[g] = local_state[2*(NUM_DATA+g)+`ASCR_PWR_DOWN_BIT];
  end

  // only the committed copy drives the limit outputs, reads show the shadow; it caps capability, the clock rate is untouched
  assign limit_enable     = limit_live_ff[`ASCR_LIMIT_ENABLE_BIT];
  assign limit_resolution = limit_live_ff[5:4];
  assign limit_rate       = limit_live_ff[2:0];
  assign sdio_pulldown_off                = io2_ff[`ASCR_SDIO_PD_OFF_BIT];
  assign common_mode_voltage_generator_pd = io3_ff[`ASCR_CM_GEN_PD_BIT];
  assign sync_enable    = sync_ff[`ASCR_SYNC_ENABLE_BIT];
  assign sync_next_only = sync_ff[`ASCR_SYNC_NEXT_BIT];
endmodule : ascr_regs

// ### ascr_regs_assertions.sv
module ascr_regs_assertions (
  input wire logic                 clock,
  input wire logic                 nrst,
  input wire logic                 reg_wr_en,
  input wire logic                 reg_rd_en,
  input wire ascr_pkg::ascr_addr_t reg_addr,
  input wire ascr_pkg::ascr_byte_t reg_wr_data,
  input wire ascr_pkg::ascr_byte_t reg_rd_data,
  input wire logic                 reg_rd_valid,
  input wire logic                 out_lsb_first,
  input wire logic                 limit_enable,
  input wire logic                 sdio_pulldown_off,
  input wire logic                 common_mode_voltage_generator_pd,
  input wire logic                 sync_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // writes land on the next cycle, no commit step except the limit
  AST_PULLDOWN_OFF: assert property (reg_wr_en && reg_addr == 9'h101
    |=> sdio_pulldown_off == $past(reg_wr_data[0])) else $error("pull-down bit wrong");
  AST_CM_GEN_PD: assert property (reg_wr_en && reg_addr == 9'h102
    |=> common_mode_voltage_generator_pd == $past(reg_wr_data[3]))
    else $error("common-mode power-down bit wrong");
  AST_LSB_FIRST: assert property (reg_wr_en && reg_addr == 9'h021
    |=> out_lsb_first == $past(reg_wr_data[7])) else $error("bit order wrong");
  AST_SYNC_NOW: assert property (reg_wr_en && reg_addr == 9'h109
    |=> sync_enable == $past(reg_wr_data[0])) else $error("sync enable late");
  // limit only moves on a commit write with bit 0 set
  AST_LIMIT_HOLD: assert property (!(reg_wr_en && reg_addr == 9'h0FF && reg_wr_data[0])
    |=> $stable(limit_enable)) else $error("limit moved without commit");
  AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read valid missing");
  AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data))
    else $error("read port moved without read");
  AST_OPEN_ZERO: assert property (reg_rd_en && reg_addr == 9'h101
    |=> reg_rd_data == {7'h00, $past(sdio_pulldown_off)}) else $error("open bits not zero");
endmodule : ascr_regs_assertions

bind ascr_regs ascr_regs_assertions u_chk (.clock, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr,
  .reg_wr_data, .reg_rd_data, .reg_rd_valid, .out_lsb_first, .limit_enable,
  .sdio_pulldown_off, .common_mode_voltage_generator_pd, .sync_enable);

// ### ascr_regs_tb_top.sv
module ascr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, out_lsb_first, pll_low_encode_rate, limit_enable;
  logic sdio_pulldown_off, common_mode_voltage_generator_pd, sync_enable, sync_next_only;
  logic [15:0] test_word_one, test_word_two;
  logic [7:0] chan_power_down, chan_output_reset;
  logic [2:0] out_lane_mode, limit_rate;
  logic [1:0] out_bit_count, clk_chan_power_down, limit_resolution;
  ascr_pkg::ascr_addr_t reg_addr;
  ascr_pkg::ascr_byte_t reg_wr_data, reg_rd_data;
  ascr_pkg::ascr_byte_t exp_q[$];
  ascr_pkg::ascr_byte_t d[9];
  ascr_pkg::ascr_addr_t ra[9] = '{9'h019, 9'h01A, 9'h01B, 9'h01C, 9'h021, 9'h100, 9'h101,
                                  9'h102, 9'h109};
  ascr_pkg::ascr_byte_t rm[9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'h77, 8'h01, 8'h08, 8'h03};
  ascr_pkg::ascr_addr_t ta[14] = '{9'h004, 9'h005, 9'h019, 9'h01A, 9'h01B, 9'h01C, 9'h021,
                                   9'h022, 9'h0FF, 9'h100, 9'h101, 9'h102, 9'h109, 9'h0F0};
  ascr_pkg::ascr_byte_t te[14] = '{8'h0F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int seed = 50;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  ascr_regs dut (.clock, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
    .reg_rd_valid, .test_word_one, .test_word_two, .out_lsb_first, .out_lane_mode,
    .pll_low_encode_rate, .out_bit_count, .chan_power_down, .chan_output_reset,
    .clk_chan_power_down, .limit_enable, .limit_resolution, .limit_rate, .sdio_pulldown_off,
    .common_mode_voltage_generator_pd, .sync_enable, .sync_next_only);
  ascr_host_model host (.clock, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);

  initial
  begin
    forever #50 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk_out(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_out

  task automatic chk_rd(input ascr_pkg::ascr_byte_t exp, input ascr_pkg::ascr_byte_t got);
    chk_out("read data", {8'h00, exp}, {8'h00, got});
  endtask : chk_rd

  task automatic wr(input ascr_pkg::ascr_addr_t a, input ascr_pkg::ascr_byte_t v, input int g);
    host.xfer(1'b1, a, v, g);
  endtask : wr

  // the note goes on the queue before the request, so the watcher never runs dry
  task automatic rd(input ascr_pkg::ascr_addr_t a, input ascr_pkg::ascr_byte_t e, input int g);
    exp_q.push_back(e);
    host.xfer(1'b0, a, ascr_pkg::ascr_byte_t'($random(seed)), g);
  endtask : rd

  // read watcher and hang guard; outputs only move on the rising edge
  always @(negedge clock)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      err_total++;
      report_and_stop();
    end
    else if (reg_rd_valid === 1'b1)
      chk_rd(exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, reg_rd_data);
  end

  initial
  begin
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    for (int i = 0; i < 14; i++)
      rd(ta[i], te[i], 0);
    foreach (d[i])
    begin
      d[i] = ascr_pkg::ascr_byte_t'($random(seed));
      wr(ra[i], d[i], 0);
      rd(ra[i], d[i] & rm[i], 0);
    end
    chk_out("pattern one", {d[1], d[0]}, test_word_one);
    chk_out("pattern two", {d[3], d[2]}, test_word_two);
    chk_out("stream", 16'({d[4][7:3], d[4][1:0]}), 16'({out_lsb_first, out_lane_mode,
      pll_low_encode_rate, out_bit_count}));
    chk_out("pulldown", 16'(d[6][0]), 16'(sdio_pulldown_off));
    chk_out("cm generator", 16'(d[7][3]), 16'(common_mode_voltage_generator_pd));
    chk_out("sync", 16'(d[8][1:0]), 16'({sync_next_only, sync_enable}));
    wr(9'h0FF, 8'hFE, 0);
    chk_out("limit early", 16'h0000,
      16'({limit_enable, limit_resolution, limit_rate}));
    host.commit(1);
    chk_out("limit", 16'({d[5][6:4], d[5][2:0]}),
      16'({limit_enable, limit_resolution, limit_rate}));
    wr(9'h004, 8'h01, 0);
    wr(9'h005, 8'h00, 0);
    wr(9'h022, 8'h03, 1);
    chk_out("chan zero", 16'h0101, {chan_power_down, chan_output_reset});
    wr(9'h004, 8'h00, 0);
    wr(9'h005, 8'h30, 0);
    wr(9'h022, 8'h03, 1);
    chk_out("clock pd", 16'h0003, 16'(clk_chan_power_down));
    chk_out("data kept", 16'h0101, {chan_power_down, chan_output_reset});
    rd(9'h022, 8'h01, 0);
    wr(9'h005, 8'h01, 0);
    wr(9'h022, 8'h02, 1);
    chk_out("chan four", 16'h0111, {chan_power_down, chan_output_reset});
    wr(9'h0F0, 8'hFF, 0);
    rd(9'h0F0, 8'h00, 3);
    chk_out("pending reads", 16'h0000, 16'(exp_q.size()));
    report_and_stop();
  end
endmodule : ascr_regs_tb_top
